// [core/lfr_fault_regs.sv]
// Fault flags, over-temperature threshold and channel 1 peak-current level registers with frame responses.
// Assumes gate-supply and peak comparators arrive asynchronously and the temperature sample is on clk.
`timescale 1ns/100ps
module lfr_fault_regs
	import lfr_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            sck,
	input  wire logic            csN,
	input  wire logic            mosi,
	output logic                 miso,
	input  wire logic            gateSupplyLow1,
	input  wire logic            gateSupplyLow2,
	input  wire logic [7:0]      temperatureSample,
	input  wire logic            peakReached1,
	output logic                 highSideEn1,
	output logic                 highSideEn2,
	output logic [7:0]           peakLevel1,
	output logic                 onTimeEnd1,
	output logic                 overTempNow
);
	import lfr_pkg::*;

	// ----------------------------------------------------------------
	// Serial frame engine
	// ----------------------------------------------------------------
	logic        frameDone;
	lfr_cmd_s    cmd;
	logic        lengthErr;
	logic [15:0] respFrame_r;

	lfr_serial_link uLink (
		.clk       (clk),
		.reset_n   (reset_n),
		.sck       (sck),
		.csN       (csN),
		.mosi      (mosi),
		.respFrame (respFrame_r),
		.miso      (miso),
		.frameDone (frameDone),
		.frameWord (cmd),
		.lengthErr (lengthErr)
	);

	// ----------------------------------------------------------------
	// Analog comparator synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cmpMeta_r;
	logic [2:0] cmpSync_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cmpMeta_r <= 3'h0;
			cmpSync_r <= 3'h0;
		end
		else
		begin
			cmpMeta_r <= {peakReached1, gateSupplyLow2, gateSupplyLow1};
			cmpSync_r <= cmpMeta_r;
		end
	end

	logic       uv1Cond;
	logic       uv2Cond;
	logic       otCond;
	logic [7:0] otThr_r;
	logic [7:0] pk1_r;

	assign uv1Cond = cmpSync_r[0];
	assign uv2Cond = cmpSync_r[1];
	assign otCond  = temperatureSample > otThr_r;

	// ----------------------------------------------------------------
	// Command checks
	// ----------------------------------------------------------------
	logic parityErr;
	logic readDataErr;
	logic frameErr;
	logic faultRead;
	logic writeOk;

	assign parityErr   = !lfr_parity_ok(16'(cmd));
	assign readDataErr = !cmd.write && (cmd.data != 9'h000);
	assign frameErr    = lengthErr || parityErr || readDataErr;
	assign faultRead   = frameDone && !cmd.write && (cmd.addr == ADDR_FAULT);
	assign writeOk     = frameDone && cmd.write && !frameErr;

	// ----------------------------------------------------------------
	// Set-point registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			otThr_r <= OT_THR_RST;
		else if (writeOk && cmd.addr == ADDR_OT_THR)
			otThr_r <= cmd.data[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			pk1_r <= PK1_RST;
		else if (writeOk && cmd.addr == ADDR_PK1)
			pk1_r <= cmd.data[7:0];
	end

	// ----------------------------------------------------------------
	// Fault flags
	// ----------------------------------------------------------------
	lfr_flags_s flags_r;
	lfr_flags_s flags_nxt;

	// A condition still present re-sets its flag in the clearing cycle, so a
	// read clears the latched flags only once their condition has gone.
	always_comb
	begin
		flags_nxt.por = flags_r.por && !faultRead;
		flags_nxt.uv2 = uv2Cond || (flags_r.uv2 && !faultRead);
		flags_nxt.uv1 = uv1Cond || (flags_r.uv1 && !faultRead);
		flags_nxt.ot  = otCond || (flags_r.ot && !faultRead);
		flags_nxt.ser = (frameDone && frameErr) || (flags_r.ser && !faultRead);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			flags_r <= lfr_flags_s'(FAULT_RST);
		else
			flags_r <= flags_nxt;
	end

	// ----------------------------------------------------------------
	// Response frame
	// ----------------------------------------------------------------
	logic [8:0]  readData;
	logic        respFaultBit;
	logic [15:0] resp;

	always_comb
	begin
		unique case (cmd.addr)
			ADDR_FAULT:  readData = {4'h0, flags_r};
			ADDR_OT_THR: readData = {1'b0, otThr_r};
			ADDR_PK1:    readData = {1'b0, pk1_r};
			ADDR_TEMP:   readData = {1'b0, temperatureSample};
			default:     readData = 9'h000;
		endcase
	end

	always_comb
	begin
		respFaultBit = flags_r.ser || frameErr;
		if (cmd.write && frameErr)
			resp = ERR_FRAME;
		else if (cmd.write)
			resp = {respFaultBit, 1'b1, cmd.addr, cmd.data};
		else
			resp = {respFaultBit, RESP_RSVD, flags_r.por, flags_r.uv2, flags_r.uv1, flags_r.ot, readData};
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			respFrame_r <= ERR_FRAME;
		else if (frameDone)
			respFrame_r <= resp;
	end

	// ----------------------------------------------------------------
	// Converter-facing outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			highSideEn1 <= 1'b0;
			highSideEn2 <= 1'b0;
			peakLevel1  <= PK1_RST;
			onTimeEnd1  <= 1'b0;
			overTempNow <= 1'b0;
		end
		else
		begin
			highSideEn1 <= !uv1Cond;
			highSideEn2 <= !uv2Cond;
			peakLevel1  <= pk1_r;
			onTimeEnd1  <= cmpSync_r[2];
			overTempNow <= otCond;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	por_after_reset_a: assert property ($rose(reset_n) |-> flags_r.por)
		else $error("Power-on flag not set after reset.");
	por_read_clear_a: assert property (faultRead |=> !flags_r.por)
		else $error("Power-on flag survived a fault read.");
	uv_latch_a: assert property (uv1Cond |=> flags_r.uv1 && !highSideEn1)
		else $error("Gate-supply-low did not set flag and disable high side.");
	uv_hold_a: assert property (flags_r.uv2 && !faultRead |=> flags_r.uv2)
		else $error("Gate-supply-low flag dropped without a read.");
	ot_set_a: assert property (temperatureSample > otThr_r |=> flags_r.ot ##0 overTempNow)
		else $error("Over-temperature flag not set.");
	ot_read_keep_a: assert property (faultRead && otCond |=> flags_r.ot)
		else $error("Over-temperature flag cleared while still present.");
	ser_set_a: assert property (frameDone && frameErr |=> flags_r.ser && respFrame_r[RESP_FAULT_POS])
		else $error("Serial error not latched or not reported.");
	bad_write_a: assert property (frameDone && cmd.write && frameErr |=> $stable(otThr_r) && $stable(pk1_r))
		else $error("Errored write changed a register.");
	read_flags_a: assert property (frameDone && !cmd.write |=>
		respFrame_r[12:9] == $past({flags_r.por, flags_r.uv2, flags_r.uv1, flags_r.ot}))
		else $error("Read response lacks current flags.");
	dac_follow_a: assert property (writeOk && cmd.addr == ADDR_PK1 |-> ##2 peakLevel1 == $past(cmd.data[7:0], 2))
		else $error("Peak level did not reach converter in time.");

	// ----------------------------------------------------------------
	// Flag setting, clearing and set priority
	// ----------------------------------------------------------------
	uv2_latch_a: assert property (uv2Cond |=> flags_r.uv2 && !highSideEn2)
		else $error("Channel 2 gate-supply-low did not set flag and disable high side.");
	uv_clear_a: assert property (faultRead && !uv1Cond |=> !flags_r.uv1)
		else $error("Gate-supply-low flag survived a read after the condition left.");
	uv_read_keep_a: assert property (faultRead && uv2Cond |=> flags_r.uv2)
		else $error("Gate-supply-low flag cleared while still present.");
	ot_clear_a: assert property (faultRead && !otCond |=> !flags_r.ot)
		else $error("Over-temperature flag survived a read after the condition left.");
	ser_clear_a: assert property (faultRead && !frameErr |=> !flags_r.ser)
		else $error("Serial fault flag survived a clean fault read.");
	set_wins_a: assert property (faultRead && frameErr |=> flags_r.ser)
		else $error("Fault read cleared a serial error raised in the same cycle.");

	// ----------------------------------------------------------------
	// Serial checks and responses
	// ----------------------------------------------------------------
	length_err_a: assert property (frameDone && lengthErr |=> flags_r.ser)
		else $error("Misaligned frame length not flagged.");
	parity_err_a: assert property (frameDone && !lfr_parity_ok(16'(cmd)) |=> flags_r.ser)
		else $error("Parity failure not flagged.");
	resp_spe_a: assert property (frameDone && flags_r.ser |=> respFrame_r[RESP_FAULT_POS])
		else $error("Latched serial fault missing from response.");
	write_resp_a: assert property (writeOk |=>
		respFrame_r == {$past(flags_r.ser), 1'b1, $past(cmd.addr), $past(cmd.data)})
		else $error("Write response does not echo the accepted command.");

	// ----------------------------------------------------------------
	// Set-point registers and converter outputs
	// ----------------------------------------------------------------
	ot_write_a: assert property (writeOk && cmd.addr == ADDR_OT_THR |=> otThr_r == $past(cmd.data[7:0]))
		else $error("Accepted threshold write did not land.");
	pk_write_a: assert property (writeOk && cmd.addr == ADDR_PK1 |=> pk1_r == $past(cmd.data[7:0]))
		else $error("Accepted peak-current write did not land.");
	on_time_end_a: assert property (cmpSync_r[2] |=> onTimeEnd1)
		else $error("Peak comparator did not end the on-time.");

	// Counts the cycles in which the converter level still differs from the register.
	logic [7:0] dacLag_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			dacLag_r <= 8'h00;
		else if (peakLevel1 != pk1_r)
			dacLag_r <= dacLag_r + 8'h01;
		else
			dacLag_r <= 8'h00;
	end

	dac_settle_a: assert property (dacLag_r < 8'(DAC_SETTLE_CYC))
		else $error("Peak level took too long to reach the converter.");

	// ----------------------------------------------------------------
	// Cover points
	// ----------------------------------------------------------------
	fault_read_c: cover property (faultRead ##1 !flags_r.por);
	write_ok_c: cover property (writeOk && cmd.addr == ADDR_PK1);
	length_err_c: cover property (frameDone && lengthErr);
	uv_event_c: cover property ($rose(uv1Cond));
	set_wins_c: cover property (faultRead && frameErr);

endmodule : lfr_fault_regs

// [core/lfr_pkg.sv]
// Constants, field layouts and carrier types for the fault-status and set-point register slice.
// Assumes a single 125 MHz system clock and a synchronous, active-low power-on reset.
package lfr_pkg;

	// ----------------------------------------------------------------
	// Frame and register geometry
	// ----------------------------------------------------------------
	localparam int          FRAME_W      = 16;
	localparam int          DATA_W       = 9;
	localparam int          ADDR_W       = 5;
	localparam logic [4:0]  ADDR_FAULT   = 5'h01;
	localparam logic [4:0]  ADDR_OT_THR  = 5'h02;
	localparam logic [4:0]  ADDR_PK1     = 5'h03;
	localparam logic [4:0]  ADDR_TEMP    = 5'h09;

	// ----------------------------------------------------------------
	// Fault flag positions and reset values
	// ----------------------------------------------------------------
	localparam int          BIT_POR      = 4;
	localparam int          BIT_UV2      = 3;
	localparam int          BIT_UV1      = 2;
	localparam int          BIT_OT       = 1;
	localparam int          BIT_SER      = 0;
	localparam logic [4:0]  FAULT_RST    = 5'h10;
	localparam logic [7:0]  OT_THR_RST   = 8'h80;
	localparam logic [7:0]  PK1_RST      = 8'h80;

	// ----------------------------------------------------------------
	// Response frame constants
	// ----------------------------------------------------------------
	localparam logic [15:0] ERR_FRAME    = 16'h8000;
	localparam logic [1:0]  RESP_RSVD    = 2'h3;
	localparam int          RESP_FAULT_POS = 15;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          DAC_SETTLE_NS = 1000;
	localparam int          DAC_SETTLE_CYC = DAC_SETTLE_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              write;
		logic [4:0]        addr;
		logic              parity;
		logic [8:0]        data;
	} lfr_cmd_s;

	typedef struct packed {
		logic              por;
		logic              uv2;
		logic              uv1;
		logic              ot;
		logic              ser;
	} lfr_flags_s;

	// Odd parity over the whole command frame, parity bit included.
	function automatic logic lfr_parity_ok(input logic [15:0] frame);
		return ^frame;
	endfunction : lfr_parity_ok

endpackage : lfr_pkg

// [core/lfr_serial_link.sv]
// Serial frame engine: synchronises the serial pins, shifts command frames in and response frames out.
// Assumes the serial clock is at most one quarter of the system clock and chip select idles high.
`timescale 1ns/100ps
module lfr_serial_link
	import lfr_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            sck,
	input  wire logic            csN,
	input  wire logic            mosi,
	input  wire logic [15:0]     respFrame,
	output logic                 miso,
	output logic                 frameDone,
	output lfr_pkg::lfr_cmd_s    frameWord,
	output logic                 lengthErr
);
	import lfr_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0]  meta_r;
	logic [2:0]  sync_r;
	logic [2:0]  last_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			meta_r <= 3'h3;
			sync_r <= 3'h3;
			last_r <= 3'h3;
		end
		else
		begin
			meta_r <= {csN, sck, mosi};
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	logic csLow;
	logic sckRise;
	logic sckFall;
	logic csFall;
	logic csRise;

	assign csLow   = !sync_r[2];
	assign sckRise = csLow && sync_r[1] && !last_r[1];
	assign sckFall = csLow && !sync_r[1] && last_r[1];
	assign csFall  = !sync_r[2] && last_r[2];
	assign csRise  = sync_r[2] && !last_r[2];

	// ----------------------------------------------------------------
	// Receive side
	// ----------------------------------------------------------------
	logic [15:0] rxShift_r;
	logic [3:0]  bitMod_r;
	logic        anyBit_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			rxShift_r <= 16'h0000;
			bitMod_r  <= 4'h0;
			anyBit_r  <= 1'b0;
		end
		else if (csFall)
		begin
			bitMod_r <= 4'h0;
			anyBit_r <= 1'b0;
		end
		else if (sckRise)
		begin
			rxShift_r <= {rxShift_r[14:0], sync_r[0]};
			bitMod_r  <= bitMod_r + 4'h1;
			anyBit_r  <= 1'b1;
		end
	end

	// Frames with no clock pulse at all carry no command and are dropped silently.
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			frameDone <= 1'b0;
			frameWord <= '0;
			lengthErr <= 1'b0;
		end
		else
		begin
			frameDone <= csRise && anyBit_r;
			if (csRise && anyBit_r)
			begin
				frameWord <= lfr_cmd_s'(rxShift_r);
				lengthErr <= bitMod_r != 4'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmit side
	// ----------------------------------------------------------------
	logic [15:0] txShift_r;

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			txShift_r <= 16'h0000;
		else if (csFall)
			txShift_r <= respFrame;
		else if (sckFall)
			txShift_r <= {txShift_r[14:0], 1'b0};
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			miso <= 1'b0;
		else if (csFall)
			miso <= respFrame[15];
		else if (sckFall)
			miso <= txShift_r[14];
		else if (!csLow)
			miso <= 1'b0;
	end

endmodule : lfr_serial_link

// [tb/lfr_host_model.sv]
// Serial bus controller model that sends command frames of a chosen bit count to the register slice.
// Assumes the system clock paces every serial edge and the device answers on miso.
`timescale 1ns/100ps
module lfr_host_model
(
	input  wire logic clk,
	output logic      sck,
	output logic      csN,
	output logic      mosi,
	input  wire logic miso
);
	localparam int HALF = 6;

	initial
	begin
		sck  = 1'h0;
		csN  = 1'h1;
		mosi = 1'h0;
	end

	// ----------------------------------------------------------------
	// One transfer
	// ----------------------------------------------------------------
	// The serial clock only moves inside a frame; data in is inverted once the frame ends.
	// Only the first 16 reply bits are kept, so an overlong frame still yields the whole reply.
	task automatic xfer(input logic [16:0] frame, input int nb, output logic [15:0] resp);
		resp = 16'h0000;
		@(posedge clk) csN <= 1'h0;
		for (int i = nb - 1; i >= 0; i--)
		begin
			@(posedge clk) mosi <= frame[i];
			repeat (HALF) @(posedge clk);
			if (nb - 1 - i < 16)
				resp = {resp[14:0], miso};
			sck <= 1'h1;
			repeat (HALF) @(posedge clk);
			sck <= 1'h0;
		end
		repeat (HALF) @(posedge clk);
		csN  <= 1'h1;
		mosi <= ~mosi;
		repeat (12) @(posedge clk);
	endtask : xfer
endmodule : lfr_host_model

// [tb/lfr_fault_regs_tb.sv]
// Self-checking bench for the fault and set-point register slice, driven through the host model.
// Assumes the package, design and host model are compiled first; one 125 MHz clock.
`timescale 1ns/100ps
module lfr_fault_regs_tb;
	import lfr_pkg::*;

	logic        clk;
	logic        reset_n;
	logic        sck;
	logic        csN;
	logic        mosi;
	logic        miso;
	logic        gateSupplyLow1;
	logic        gateSupplyLow2;
	logic [7:0]  temperatureSample;
	logic        peakReached1;
	logic        highSideEn1;
	logic        highSideEn2;
	logic [7:0]  peakLevel1;
	logic        onTimeEnd1;
	logic        overTempNow;
	logic [15:0] pendExp;
	logic        pendEn;
	int          errors = 0;
	int          num_checks = 0;
	int          cycles = 0;

	lfr_fault_regs DUT (.clk(clk), .reset_n(reset_n), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso),
		.gateSupplyLow1(gateSupplyLow1), .gateSupplyLow2(gateSupplyLow2),
		.temperatureSample(temperatureSample), .peakReached1(peakReached1), .highSideEn1(highSideEn1),
		.highSideEn2(highSideEn2), .peakLevel1(peakLevel1), .onTimeEnd1(onTimeEnd1),
		.overTempNow(overTempNow));

	lfr_host_model host (.clk(clk), .sck(sck), .csN(csN), .mosi(mosi), .miso(miso));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	// Sends one command and checks the reply it carries for the command before it.
	// bad: bit 0 spoils the parity, bit 1 adds a seventeenth clock pulse.
	task automatic op(input logic wr, input logic [4:0] a, input logic [8:0] d, input logic [1:0] bad,
		input logic [15:0] exp, input logic en);
		logic [15:0] f;
		logic [15:0] resp;
		f    = {wr, a, 1'h0, d};
		f[9] = ~^f ^ bad[0];
		host.xfer({bad[1], f}, bad[1] ? 17 : 16, resp);
		if (pendEn)
			check(resp, pendExp);
		pendExp = exp;
		pendEn  = en;
	endtask : op

	task automatic give_verdict;
		if (errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset_n           = 1'h0;
		gateSupplyLow1    = 1'h0;
		gateSupplyLow2    = 1'h0;
		temperatureSample = 8'h00;
		peakReached1      = 1'h0;
		pendExp           = 16'h8000;
		pendEn            = 1'h1;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge clk);
		peakReached1 <= 1'h1;
		repeat (5) @(posedge clk);
		check({15'h0000, onTimeEnd1}, 16'h0001);
		peakReached1 <= 1'h0;
		repeat (5) @(posedge clk);
		check({15'h0000, onTimeEnd1}, 16'h0000);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h7010, 1'h1);
		op(1'h0, 5'h02, 9'h000, 2'h0, 16'h6080, 1'h1);
		op(1'h0, 5'h03, 9'h000, 2'h0, 16'h6080, 1'h1);
		op(1'h1, 5'h03, 9'h0FF, 2'h0, 16'h46FF, 1'h1);
		check({8'h00, peakLevel1}, 16'h00FF);
		op(1'h1, 5'h02, 9'h1FF, 2'h0, 16'h45FF, 1'h1);
		op(1'h0, 5'h02, 9'h000, 2'h0, 16'h60FF, 1'h1);
		op(1'h1, 5'h03, 9'h055, 2'h2, 16'h8000, 1'h1);
		op(1'h0, 5'h03, 9'h000, 2'h0, 16'hE0FF, 1'h1);
		op(1'h1, 5'h03, 9'h011, 2'h1, 16'h8000, 1'h1);
		op(1'h0, 5'h03, 9'h000, 2'h0, 16'hE0FF, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'hE001, 1'h1);
		op(1'h0, 5'h02, 9'h001, 2'h0, 16'hE0FF, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'hE001, 1'h1);
		op(1'h1, 5'h02, 9'h010, 2'h0, 16'h4410, 1'h1);
		temperatureSample <= 8'h10;
		repeat (4) @(posedge clk);
		check({15'h0000, overTempNow}, 16'h0000);
		temperatureSample <= 8'h11;
		repeat (4) @(posedge clk);
		check({15'h0000, overTempNow}, 16'h0001);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6202, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6202, 1'h1);
		temperatureSample <= 8'h00;
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6202, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6000, 1'h1);
		gateSupplyLow1 <= 1'h1;
		gateSupplyLow2 <= 1'h1;
		repeat (6) @(posedge clk);
		check({14'h0000, highSideEn1, highSideEn2}, 16'h0000);
		gateSupplyLow1 <= 1'h0;
		op(1'h0, 5'h02, 9'h000, 2'h0, 16'h6C10, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6C0C, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6808, 1'h1);
		gateSupplyLow2 <= 1'h0;
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6808, 1'h1);
		check({14'h0000, highSideEn1, highSideEn2}, 16'h0003);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6000, 1'h1);
		op(1'h0, 5'h01, 9'h001, 2'h0, 16'hE000, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'hE001, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h6000, 1'h1);
		op(1'h0, 5'h01, 9'h000, 2'h0, 16'h0000, 1'h0);
		give_verdict();
	end
endmodule : lfr_fault_regs_tb
